// >>> verilog/csc_pkg.sv
// Constants, register map and state codes of the capacitive sense scan controller
//
// Overview of operation
// - Unit runs only while sense_enable is 1; otherwise shut down, no conversions.
// - gain_select picks gain 1x (000b) to 8x (111b); resets to 8x.
// - Conversion time grows as gain drops: 31 us at 8x, 178 us at 1x.
// - Trigger field bits 6:4 picks software, timer 0/2/1/3, continuous or auto-scan.
// - Continuous modes start only after convert_busy is set, then run back to back.
// - Completion requests an interrupt when complete_irq_enable is set.
// - resolution_select gives 12, 13, 14 or 16 bits, default 13; unconverted bits zero.
// - With accumulation, the completion interrupt comes once, after the last conversion.
// - In auto-scan, writing scan_start_channel also loads channel_select.
// - Auto-scan needs start/end channels programmed and starts on a convert_busy write.
// - After each accumulated set auto-scan steps channel_select up to scan_end_channel.
// - After the end channel auto-scan reloads the start channel and keeps rotating.
// - During conversion ground other reachable analog pins whose port latch is 0.
// - Auto-scan converts every channel in range whether analog-configured or not.
// - A debug halt does not stop the auto-scan rotation in progress.
// - Auto-scan keeps running while the device is in suspend.
// - Each comparison sets greater_flag if result exceeds threshold, else clears it.
// - With accumulation, compare only after the last conversion is accumulated.
// - greater_flag set with greater_irq_enable requests a greater-than interrupt.
// - A greater event stops auto-scan until convert_busy is written 1 again.
// - A greater event wakes the device from suspend even with its interrupt disabled.
// - Accumulate 1/4/8/16/32/64 conversions, divide by the count, store as result.
// - Auto-scan holds channel on a greater event, else increments and wraps at end.
package csc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL    = 8'h00;
    localparam logic [7:0] OFF_MODE_ONE   = 8'h04;
    localparam logic [7:0] OFF_MODE_TWO   = 8'h08;
    localparam logic [7:0] OFF_CONFIG     = 8'h0C;
    localparam logic [7:0] OFF_THR_LOW    = 8'h10;
    localparam logic [7:0] OFF_THR_HIGH   = 8'h14;
    localparam logic [7:0] OFF_RES_LOW    = 8'h18;
    localparam logic [7:0] OFF_RES_HIGH   = 8'h1C;
    localparam logic [7:0] OFF_SCAN_START = 8'h20;
    localparam logic [7:0] OFF_SCAN_END   = 8'h24;
    localparam logic [7:0] OFF_CHAN_SEL   = 8'h28;
    localparam logic [7:0] OFF_IRQ_EN     = 8'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_ENABLE_BIT  = 0;
    localparam int CTL_GREATER_BIT = 1;
    localparam int CTL_BUSY_BIT    = 4;
    localparam int CTL_DONE_BIT    = 5;
    localparam int CFG_TRIG_LSB    = 4;
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_GREATER_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] GAIN_RESET  = 3'h7;
    localparam logic [1:0] RES_RESET   = 2'h1;
    localparam logic [2:0] TRIG_RESET  = 3'h0;
    localparam logic [2:0] ACCUM_RESET = 3'h0;

    // ------------------------------------------------------------
    // Trigger codes
    // ------------------------------------------------------------
    localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
    localparam logic [2:0] TRIG_TIMER0   = 3'h1;
    localparam logic [2:0] TRIG_TIMER2   = 3'h2;
    localparam logic [2:0] TRIG_TIMER1   = 3'h3;
    localparam logic [2:0] TRIG_TIMER3   = 3'h4;
    localparam logic [2:0] TRIG_CONT_A   = 3'h5;
    localparam logic [2:0] TRIG_CONT_B   = 3'h6;
    localparam logic [2:0] TRIG_AUTOSCAN = 3'h7;

    // ------------------------------------------------------------
    // Timing: nominal conversion time per gain code, 13-bit basis
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int NOMINAL_BITS  = 13;
    localparam int CONV_US [8]   = '{178, 93, 66, 52, 43, 38, 34, 31};
    localparam int RES_BITS [4]  = '{12, 13, 14, 16};
    localparam int ACC_SHIFT [8] = '{0, 2, 3, 4, 5, 6, 0, 0};

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_IDLE = 3'b010,
        ST_CONV = 3'b100
    } csc_state_type;

endpackage

// >>> verilog/csc_scan_ctrl.sv
// Capacitive sense scan controller with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module csc_scan_ctrl #(
    parameter int NCH          = 38,
    parameter int CHW          = 6,
    parameter int CYCLES_PER_US = csc_pkg::CLK_MHZ
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [7:0]       awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    input  wire logic [7:0]       araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    input  wire logic [3:0]       timerOverflow,
    input  wire logic [15:0]      rawCode,
    input  wire logic [NCH-1:0]   analogInput,
    input  wire logic [NCH-1:0]   portLatch,
    output logic                  senseOn,
    output logic                  converting,
    output logic [CHW-1:0]        channelSelect,
    output logic [2:0]            gainSelect,
    output logic [1:0]            resolutionSelect,
    output logic [NCH-1:0]        pinGround,
    output logic                  completeIrq,
    output logic                  greaterIrq,
    output logic                  wakeRequest
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        csc_pkg::csc_state_type st;
        logic                   enable;
        logic [2:0]             gain;
        logic [1:0]             res;
        logic [2:0]             trig;
        logic [2:0]             accSel;
        logic [7:0]             thrLow;
        logic [7:0]             thrHigh;
        logic [15:0]            result;
        logic [CHW-1:0]         scanStart;
        logic [CHW-1:0]         scanEnd;
        logic [CHW-1:0]         chan;
        logic                   doneIrqEn;
        logic                   grtIrqEn;
        logic                   busy;
        logic                   run;
        logic                   doneFlag;
        logic                   greaterFlag;
        logic [23:0]            cnt;
        logic [21:0]            acc;
        logic [6:0]             nAcc;
        logic [NCH-1:0]         ground;
        logic                   doneIrq;
        logic                   grtIrq;
        logic                   wake;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [1:0]             rresp;
        logic [31:0]            rdata;
    } csc_regs_type;

    csc_regs_type s_q;
    csc_regs_type s_d;

    // ------------------------------------------------------------
    // Derived values
    // ------------------------------------------------------------
    logic        wrFire;
    logic        rdFire;
    logic [7:0]  wrAddr;
    logic [7:0]  rdAddr;
    logic [7:0]  wd;
    logic [23:0] convLen;
    logic [15:0] resMask;
    logic [15:0] sample;
    logic [21:0] accSum;
    logic [6:0]  accLen;
    logic [15:0] avg;
    logic        isGreater;
    logic        contMode;
    logic        startNow;
    logic [NCH-1:0] groundNext;

    // Handshake: both address and data taken together, one write in flight
    assign wrFire  = awvalid && wvalid && !s_q.bvalid;
    assign rdFire  = arvalid && !s_q.rvalid;
    assign awready = wrFire;
    assign wready  = wrFire;
    assign arready = !s_q.rvalid;
    assign wrAddr  = {awaddr[7:2], 2'b00};
    assign rdAddr  = {araddr[7:2], 2'b00};
    assign wd      = wstrb[0] ? wdata[7:0] : 8'h00;

    // Conversion length scales with gain and with the chosen bit count
    assign convLen = 24'(csc_pkg::CONV_US[s_q.gain] * CYCLES_PER_US
                         * csc_pkg::RES_BITS[s_q.res] / csc_pkg::NOMINAL_BITS);

    // Unconverted low bits forced to zero
    assign resMask = 16'hFFFF << (16 - csc_pkg::RES_BITS[s_q.res]);
    assign sample  = rawCode & resMask;

    // Running sum, set length and quotient
    assign accSum    = s_q.acc + {6'h00, sample};
    assign accLen    = 7'(1 << csc_pkg::ACC_SHIFT[s_q.accSel]);
    assign avg       = 16'(accSum >> csc_pkg::ACC_SHIFT[s_q.accSel]);
    assign isGreater = avg > {s_q.thrHigh, s_q.thrLow};

    assign contMode = (s_q.trig == csc_pkg::TRIG_CONT_A) || (s_q.trig == csc_pkg::TRIG_CONT_B)
                      || (s_q.trig == csc_pkg::TRIG_AUTOSCAN);

    // Start source selection
    always_comb begin
        case (s_q.trig)
            csc_pkg::TRIG_SOFTWARE: startNow = s_q.busy;
            csc_pkg::TRIG_TIMER0:   startNow = timerOverflow[0];
            csc_pkg::TRIG_TIMER2:   startNow = timerOverflow[2];
            csc_pkg::TRIG_TIMER1:   startNow = timerOverflow[1];
            csc_pkg::TRIG_TIMER3:   startNow = timerOverflow[3];
            default:                startNow = s_q.run;
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        s_d.doneIrq = 1'b0;
        s_d.grtIrq  = 1'b0;
        s_d.wake    = 1'b0;

        // Bus response release
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end

        // Register writes
        if (wrFire) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = csc_pkg::RESP_OKAY;
            case (wrAddr)
                csc_pkg::OFF_CONTROL: begin
                    s_d.enable = wd[csc_pkg::CTL_ENABLE_BIT];
                    if (wd[csc_pkg::CTL_BUSY_BIT] && wd[csc_pkg::CTL_ENABLE_BIT]) begin
                        s_d.busy = 1'b1;
                        s_d.run  = contMode;
                    end
                    if (wd[csc_pkg::CTL_DONE_BIT]) begin
                        s_d.doneFlag = 1'b0;
                    end
                end
                csc_pkg::OFF_MODE_ONE: s_d.gain   = wd[2:0];
                csc_pkg::OFF_MODE_TWO: s_d.res    = wd[1:0];
                csc_pkg::OFF_CONFIG: begin
                    s_d.trig   = wd[csc_pkg::CFG_TRIG_LSB +: 3];
                    s_d.accSel = wd[2:0];
                end
                csc_pkg::OFF_THR_LOW:  s_d.thrLow  = wd;
                csc_pkg::OFF_THR_HIGH: s_d.thrHigh = wd;
                csc_pkg::OFF_SCAN_START: begin
                    s_d.scanStart = wd[CHW-1:0];
                    if (s_q.trig == csc_pkg::TRIG_AUTOSCAN) begin
                        s_d.chan = wd[CHW-1:0];
                    end
                end
                csc_pkg::OFF_SCAN_END: s_d.scanEnd = wd[CHW-1:0];
                csc_pkg::OFF_CHAN_SEL: s_d.chan    = wd[CHW-1:0];
                csc_pkg::OFF_IRQ_EN: begin
                    s_d.doneIrqEn = wd[csc_pkg::IRQ_DONE_BIT];
                    s_d.grtIrqEn  = wd[csc_pkg::IRQ_GREATER_BIT];
                end
                csc_pkg::OFF_RES_LOW, csc_pkg::OFF_RES_HIGH: ;
                default: s_d.bresp = csc_pkg::RESP_SLVERR;
            endcase
        end

        // Register reads
        if (rdFire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = csc_pkg::RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            case (rdAddr)
                csc_pkg::OFF_CONTROL: begin
                    s_d.rdata[csc_pkg::CTL_ENABLE_BIT]  = s_q.enable;
                    s_d.rdata[csc_pkg::CTL_GREATER_BIT] = s_q.greaterFlag;
                    s_d.rdata[csc_pkg::CTL_BUSY_BIT]    = s_q.busy;
                    s_d.rdata[csc_pkg::CTL_DONE_BIT]    = s_q.doneFlag;
                end
                csc_pkg::OFF_MODE_ONE:   s_d.rdata[2:0]     = s_q.gain;
                csc_pkg::OFF_MODE_TWO:   s_d.rdata[1:0]     = s_q.res;
                csc_pkg::OFF_CONFIG:     s_d.rdata[7:0]     = {1'b0, s_q.trig, 1'b0, s_q.accSel};
                csc_pkg::OFF_THR_LOW:    s_d.rdata[7:0]     = s_q.thrLow;
                csc_pkg::OFF_THR_HIGH:   s_d.rdata[7:0]     = s_q.thrHigh;
                csc_pkg::OFF_RES_LOW:    s_d.rdata[7:0]     = s_q.result[7:0];
                csc_pkg::OFF_RES_HIGH:   s_d.rdata[7:0]     = s_q.result[15:8];
                csc_pkg::OFF_SCAN_START: s_d.rdata[CHW-1:0] = s_q.scanStart;
                csc_pkg::OFF_SCAN_END:   s_d.rdata[CHW-1:0] = s_q.scanEnd;
                csc_pkg::OFF_CHAN_SEL:   s_d.rdata[CHW-1:0] = s_q.chan;
                csc_pkg::OFF_IRQ_EN:     s_d.rdata[1:0]     = {s_q.grtIrqEn, s_q.doneIrqEn};
                default:                 s_d.rresp          = csc_pkg::RESP_SLVERR;
            endcase
        end

        // Sequencer; debug halt and suspend have no input here, so a scan
        // in progress always runs on
        case (s_q.st)
            csc_pkg::ST_OFF: begin
                s_d.busy = 1'b0;
                s_d.run  = 1'b0;
                if (s_q.enable) begin
                    s_d.st = csc_pkg::ST_IDLE;
                end
            end
            csc_pkg::ST_IDLE: begin
                if (startNow) begin
                    s_d.st   = csc_pkg::ST_CONV;
                    s_d.busy = 1'b1;
                    s_d.cnt  = convLen - 24'h000001;
                end
            end
            csc_pkg::ST_CONV: begin
                s_d.cnt = s_q.cnt - 24'h000001;
                if (s_q.cnt == 24'h000000) begin
                    if (s_q.nAcc + 7'h01 < accLen) begin
                        // More samples in this set: convert again at once
                        s_d.acc  = accSum;
                        s_d.nAcc = s_q.nAcc + 7'h01;
                        s_d.cnt  = convLen - 24'h000001;
                    end else begin
                        // Set complete: divide, compare, report
                        s_d.acc         = 22'h000000;
                        s_d.nAcc        = 7'h00;
                        s_d.result      = avg;
                        s_d.greaterFlag = isGreater;
                        s_d.doneFlag    = 1'b1;
                        s_d.doneIrq     = s_q.doneIrqEn;
                        s_d.grtIrq      = isGreater && s_q.grtIrqEn;
                        s_d.wake        = isGreater;
                        s_d.st          = csc_pkg::ST_IDLE;
                        s_d.busy        = s_d.run;
                        if (s_q.trig == csc_pkg::TRIG_AUTOSCAN) begin
                            if (isGreater) begin
                                s_d.run  = 1'b0;
                                s_d.busy = 1'b0;
                            end else if (s_q.chan == s_q.scanEnd) begin
                                s_d.chan = s_q.scanStart;
                            end else begin
                                s_d.chan = s_q.chan + 1'b1;
                            end
                        end
                    end
                end
            end
            default: s_d.st = csc_pkg::ST_OFF;
        endcase

        // Disabling forces shutdown from any state
        if (!s_d.enable) begin
            s_d.st   = csc_pkg::ST_OFF;
            s_d.busy = 1'b0;
            s_d.run  = 1'b0;
            s_d.acc  = 22'h000000;
            s_d.nAcc = 7'h00;
        end
        s_d.ground = groundNext;
    end

    // ------------------------------------------------------------
    // Pin grounding during conversion
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ground
            assign groundNext[gi] = (s_d.st == csc_pkg::ST_CONV) && analogInput[gi]
                                    && !portLatch[gi]
                                    && (s_d.chan != CHW'(gi));
        end
    endgenerate

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q           <= '0;
            s_q.st        <= csc_pkg::ST_OFF;
            s_q.gain      <= csc_pkg::GAIN_RESET;
            s_q.res       <= csc_pkg::RES_RESET;
            s_q.trig      <= csc_pkg::TRIG_RESET;
            s_q.accSel    <= csc_pkg::ACCUM_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bvalid           = s_q.bvalid;
    assign bresp            = s_q.bresp;
    assign rvalid           = s_q.rvalid;
    assign rresp            = s_q.rresp;
    assign rdata            = s_q.rdata;
    assign senseOn          = s_q.enable;
    assign converting       = (s_q.st == csc_pkg::ST_CONV);
    assign channelSelect    = s_q.chan;
    assign gainSelect       = s_q.gain;
    assign resolutionSelect = s_q.res;
    assign pinGround        = s_q.ground;
    assign completeIrq      = s_q.doneIrq;
    assign greaterIrq       = s_q.grtIrq;
    assign wakeRequest      = s_q.wake;

endmodule

// >>> testbench/csc_scan_ctrl_asserts.sv
// Port assertions for the capacitive sense scan controller
`timescale 1ns/100ps
module csc_scan_ctrl_asserts #(parameter int NCH = 38, parameter int CHW = 6,
    parameter int CYCLES_PER_US = 1) (
    input wire logic           clk, rst, senseOn, converting, bvalid,
    input wire logic           completeIrq, greaterIrq, wakeRequest,
    input wire logic [CHW-1:0] channelSelect,
    input wire logic [2:0]     gainSelect,
    input wire logic [1:0]     resolutionSelect,
    input wire logic [NCH-1:0] pinGround, analogInput, portLatch
);
    logic [15:0] cnt_q;
    // Cycles spent in the current run of conversions
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_q <= 16'h0000;
        else cnt_q <= converting ? cnt_q + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_off; !senseOn [*2] |-> !converting; endproperty
    a_off: assert property (p_off) else $error("conversion while disabled");
    property p_gnd_idle; !converting && !$past(converting) |-> pinGround == '0; endproperty
    a_gnd_idle: assert property (p_gnd_idle) else $error("pins grounded when idle");
    property p_gnd;
        converting && $past(converting) && $stable(channelSelect) && $stable(analogInput)
            && $stable(portLatch) |-> pinGround == (analogInput & ~portLatch
            & ~(NCH'(1) << channelSelect));
    endproperty
    a_gnd: assert property (p_gnd) else $error("wrong grounded pins");
    property p_len;
        $fell(converting) && senseOn |-> cnt_q != 0 && cnt_q % (csc_pkg::CONV_US[gainSelect]
            * CYCLES_PER_US * csc_pkg::RES_BITS[resolutionSelect] / 13) == 0;
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_done; completeIrq |-> $fell(converting); endproperty
    a_done: assert property (p_done) else $error("completion pulse off set end");
    property p_wake_at; wakeRequest |-> $fell(converting); endproperty
    a_wake_at: assert property (p_wake_at) else $error("compare before set end");
    property p_wake; greaterIrq |-> wakeRequest; endproperty
    a_wake: assert property (p_wake) else $error("greater without wake");
    property p_hold; wakeRequest |-> $stable(channelSelect); endproperty
    a_hold: assert property (p_hold) else $error("channel moved on greater");
    property p_step;
        $changed(channelSelect) |-> bvalid || $past(bvalid) || $fell(converting);
    endproperty
    a_step: assert property (p_step) else $error("channel moved without cause");
    c_done: cover property (completeIrq);
    c_wake: cover property (wakeRequest);
    c_adv: cover property ($fell(converting) && $changed(channelSelect));
endmodule

bind csc_scan_ctrl csc_scan_ctrl_asserts #(.NCH(NCH), .CHW(CHW), .CYCLES_PER_US(CYCLES_PER_US))
    i_asserts (.clk, .rst, .senseOn, .converting, .bvalid, .completeIrq, .greaterIrq,
    .wakeRequest, .channelSelect, .gainSelect, .resolutionSelect, .pinGround, .analogInput,
    .portLatch);

// >>> testbench/csc_electrodes.sv
// Electrode model: one code per selected channel and fixed pin setup
`timescale 1ns/100ps
module csc_electrodes #(parameter int NCH = 38, parameter int CHW = 6) (
    input  wire logic           clk,
    input  wire logic           converting,
    input  wire logic [CHW-1:0] channelSelect,
    output logic      [15:0]    rawCode,
    output logic      [NCH-1:0] analogInput,
    output logic      [NCH-1:0] portLatch
);
    logic [15:0] flip_q = 16'h5A5A;
    // Toggle outside conversions so a stale code never looks valid
    always_ff @(posedge clk) flip_q <= ~flip_q;
    assign rawCode = converting ? 16'h4000 + 16'(channelSelect) * 16'h0111 : flip_q;
    // Channel 3 is not analog, yet scans still visit it
    assign analogInput = ~(NCH'(1) << 3);
    assign portLatch = {{(NCH-16){1'b0}}, 16'hF0F0};
endmodule

// >>> testbench/csc_scan_ctrl_tb_top.sv
// Self-checking bench of the capacitive sense scan controller
`timescale 1ns/100ps
module csc_scan_ctrl_tb_top;
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic senseOn, converting, completeIrq, greaterIrq, wakeRequest;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hF, timerOverflow = 4'h0;
    logic [1:0] bresp, rresp, resolutionSelect, r;
    logic [15:0] rawCode;
    logic [37:0] analogInput, portLatch, pinGround;
    logic [5:0] channelSelect, ch0;
    logic [2:0] gainSelect;
    int error_cnt = 0, n_compared = 0, nDone = 0, nWake = 0, nGrt = 0, w0;
    int bmap [4] = '{0, 2, 1, 3};
    int chs [4] = '{2, 3, 1, 2};
    always #5 clk = ~clk;
    csc_scan_ctrl #(.CYCLES_PER_US(1)) i_csc_scan_ctrl (.*);
    csc_electrodes i_csc_electrodes (.*);
    // Count event pulses
    always @(posedge clk) begin
        if (completeIrq === 1'b1) nDone++;
        if (wakeRequest === 1'b1) nWake++;
        if (greaterIrq === 1'b1) nGrt++;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata; r = rresp; rready <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(d & m, e);
    endtask
    // Wait for the end of the next run of conversions, bounded
    task conv_end;
        int n;
        n = 0;
        while (converting !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
        while (converting !== 1'b0 && n < 3000) begin @(posedge clk); n++; end
        if (n >= 3000) chk(1'b0, 1'b1);
    endtask
    task t_reset;
        rchk(csc_pkg::OFF_MODE_ONE, 32'hFF, 32'h7);
        rchk(csc_pkg::OFF_MODE_TWO, 32'hFF, 32'h1);
        rd(8'h30);
        chk(r, csc_pkg::RESP_SLVERR);
        chk({gainSelect, resolutionSelect}, 5'h1D);
        $display("test reset done");
    endtask
    task t_soft;
        wr(csc_pkg::OFF_CHAN_SEL, 32'h2); wr(csc_pkg::OFF_CONFIG, 32'h1);
        wr(csc_pkg::OFF_THR_LOW, 32'hFF); wr(csc_pkg::OFF_THR_HIGH, 32'hFF);
        wr(csc_pkg::OFF_IRQ_EN, 32'h3); wr(csc_pkg::OFF_CONTROL, 32'h1);
        w0 = nDone; wr(csc_pkg::OFF_CONTROL, 32'h11);
        rchk(csc_pkg::OFF_CONTROL, 32'h10, 32'h10);
        conv_end; repeat (2) @(posedge clk);
        chk(nDone - w0, 1);
        rchk(csc_pkg::OFF_RES_LOW, 32'hFF, 32'h20);
        rchk(csc_pkg::OFF_RES_HIGH, 32'hFF, 32'h42);
        rchk(csc_pkg::OFF_CONTROL, 32'h12, 32'h0);
        $display("test software start done");
    endtask
    task t_timer;
        for (int c = 1; c < 5; c++) begin
            wr(csc_pkg::OFF_CONFIG, 32'(c) << 4);
            @(posedge clk) timerOverflow <= 4'(1 << ((bmap[c-1] + 1) % 4));
            @(posedge clk) timerOverflow <= 4'h0;
            repeat (3) @(posedge clk);
            chk(converting, 1'b0);
            timerOverflow <= 4'(1 << bmap[c-1]);
            @(posedge clk) timerOverflow <= 4'h0;
            conv_end;
        end
        $display("test timer starts done");
    endtask
    task t_cont;
        for (int m = 5; m < 7; m++) begin
            wr(csc_pkg::OFF_CONTROL, 32'h1); wr(csc_pkg::OFF_CONFIG, 32'(m) << 4);
            repeat (40) @(posedge clk);
            chk(converting, 1'b0);
            wr(csc_pkg::OFF_CONTROL, 32'h11); conv_end; conv_end;
            wr(csc_pkg::OFF_CONTROL, 32'h0); repeat (2) @(posedge clk);
            chk({senseOn, converting}, 2'b00);
        end
        wr(csc_pkg::OFF_CONTROL, 32'h10); repeat (40) @(posedge clk);
        chk(converting, 1'b0);
        $display("test continuous done");
    endtask
    task t_scan;
        wr(csc_pkg::OFF_CONTROL, 32'h1); wr(csc_pkg::OFF_IRQ_EN, 32'h1);
        wr(csc_pkg::OFF_CONFIG, 32'h70); wr(csc_pkg::OFF_SCAN_END, 32'h3);
        wr(csc_pkg::OFF_SCAN_START, 32'h1);
        rchk(csc_pkg::OFF_CHAN_SEL, 32'hFF, 32'h1);
        wr(csc_pkg::OFF_CONTROL, 32'h11);
        for (int i = 0; i < 4; i++) begin
            conv_end;
            chk(channelSelect, 6'(chs[i]));
        end
        wr(csc_pkg::OFF_THR_HIGH, 32'h0); ch0 = channelSelect; w0 = nWake;
        conv_end; chk(channelSelect, ch0);
        repeat (2) @(posedge clk);
        chk(nWake - w0, 1);
        chk(nGrt, 0);
        rchk(csc_pkg::OFF_CONTROL, 32'h12, 32'h2);
        repeat (60) @(posedge clk);
        chk(converting, 1'b0);
        wr(csc_pkg::OFF_IRQ_EN, 32'h3); wr(csc_pkg::OFF_CONTROL, 32'h11);
        conv_end; repeat (2) @(posedge clk);
        chk(nGrt, 1);
        $display("test auto-scan done");
    endtask
    task close_out;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #400000;
        error_cnt++;
        close_out;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset; t_soft; t_timer; t_cont; t_scan;
        close_out;
    end
endmodule
